//--- hdl/cmc_console_ctrl.sv
// Purpose: Maintenance console pushbutton control
// Assumes: Switches are slow levels; strobes are on clock_i
// Notes:   One-cycle storage requests; reads answer on mem_rvalid_i
`timescale 1ns/1ps
`include "cmc_defines.svh"
module cmc_console_ctrl
  import cmc_pkg::*;
#(
  parameter int DW = `CMC_DATA_W,     // Data word width
  parameter int AW = `CMC_ADDR_W      // Address width
)
(
  input  wire logic                        clock_i, // Clock
  input  wire logic                        rst_i, // Async reset
  input  wire logic                        ce_i, // Clock enable
  input  wire logic [`CMC_NUM_BUTTONS-1:0] buttons_i, // Raw pushbuttons
  input  wire logic                        maintenance_state_switch, // Maintenance
  input  wire logic                        fault_injection_permit, // Injection allowed
  input  wire logic                        scan_test_switch_i, // Scan test
  input  wire logic                        scan_inhibit_i, // Scan inhibit
  input  wire logic                        xs_read_sw_i, // Index read test
  input  wire logic                        xs_write_sw_i, // Index write test
  input  wire logic                        xs_err_stop_sw_i, // Stop on error
  input  wire logic                        xs_error_i, // Index parity error
  input  wire logic [DW-1:0]               operator_data_switches, // Data keys
  input  wire logic [AW-1:0]               operator_address_switches, // Operator_address_switches
  input  wire logic [1:0]                  data_pattern_sw01_i, // Pattern 01
  input  wire logic [1:0]                  data_pattern_sw10_i, // Pattern 10
  input  wire logic                        clock_stop_phase_pulse, // Stop phase
  input  wire logic                        phase_b_i, // Phase is B
  input  wire logic                        initial_start_i, // Load done
  input  wire logic                        mem_rvalid_i, // Read valid
  input  wire logic [DW-1:0]               mem_rdata_i, // Read data
  input  wire logic                        iunit_valid_i, // I unit valid
  input  wire logic                        buf_empty_i, // A buffer empty
  output logic                             mem_rd_o, // Read request
  output logic                             mem_wr_o, // Write request
  output logic [AW-1:0]                    mem_addr_o, // Storage address
  output logic [DW-1:0]                    transfer_reg_o, // Transfer register
  output logic [DW-1:0]                    instruction_buffer_one, // Buffer one
  output logic [DW-1:0]                    instruction_buffer_two, // Buffer two
  output logic [AW-1:0]                    panel_addr_o, // Panel counter
  output logic                             load_start_o, // Load pulse
  output logic                             load_fetch_o, // Fetch via 4
  output logic                             entered_inst_o, // Entry pending
  output logic                             xs_cycle_o, // Index test cycle
  output logic                             xs_rcw_o, // Read-clear-write
  output logic                             ring_reset_o, // Ring reset
  output logic                             ring_step_o, // Ring step
  output logic                             scan_start_o, // Scan start
  output logic                             inject_bit_o, // Boundary bit 58
  output logic                             ctl_pulse_o, // Controlled pulse
  output logic                             ctl_phase_b_o, // Pulse phase
  output logic                             clock_running_o, // Clock on
  output logic                             program_halt_o, // Program halt
  output logic                             halt_required_o, // Halt required
  output logic                             recovery_req_o, // Recovery required
  output logic                             recovery_go_o, // Start recovery
  output logic                             lookahead_load_o, // Lookahead load
  output logic                             fetch_next_o, // Fetch to I unit
  output logic                             indicator_clr_o, // Clear indicators
  output logic                             control_clr_o, // Clear controls
  output logic                             error_clr_o // Clear errors
);
  if (DW < 64 || AW < 4) $error("Widths too small");

  logic [`CMC_NUM_BUTTONS-1:0] lvl; // Held levels
  logic [`CMC_NUM_BUTTONS-1:0] prs; // Press pulses
  cmc_state_type               st_q; // Sequencer state
  logic [DW-1:0]               mod_data; // Modified data keys
  logic                        shown_q; // Display load pending
  logic                        stop_req_q; // Stop awaits stop phase
  logic                        btn_stop_q; // Stopped by button
  logic [1:0]                  pulses_q; // Pulses owed
  logic [1:0]                  slow_q; // Slow divider
  logic                        xs_run_q; // Index test running
  logic                        maint; // Maintenance level
  logic                        clk_stopped; // Clock stopped
  logic [AW-1:0]               next_addr; // Counter plus one

  // Synchronised presses; switches are taken as slow levels
  cmc_press_sync #(.N(`CMC_NUM_BUTTONS)) u_sync
  (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .raw_i   (buttons_i),
    .level_o (lvl),
    .press_o (prs)
  );

  assign maint       = maintenance_state_switch;
  assign clk_stopped = ~clock_running_o;
  assign next_addr   = panel_addr_o + AW'(1);

  // Pattern switches: both up gives zeros, both down ones, else OR patterns
  always_comb
  begin
    mod_data = operator_data_switches;
    if (data_pattern_sw01_i == CMC_SW_UP && data_pattern_sw10_i == CMC_SW_UP)
      mod_data = '0;
    else if (data_pattern_sw01_i == CMC_SW_DOWN && data_pattern_sw10_i == CMC_SW_DOWN)
      mod_data = '1;
    else if (data_pattern_sw01_i == CMC_SW_DOWN)
      mod_data = operator_data_switches | DW'(`CMC_DATA_PAT_01);
    else if (data_pattern_sw10_i == CMC_SW_DOWN)
      mod_data = operator_data_switches | DW'(`CMC_DATA_PAT_10);
  end

  // Excluded locations read nothing back on display; consecutive display still reads them
  function automatic logic show_ok(input logic [AW-1:0] a);
    show_ok = !(a == AW'(`CMC_PROT_ADDR) || a == AW'(`CMC_SKIP_ADDR_A) ||
                (a >= AW'(`CMC_SKIP_LO) && a <= AW'(`CMC_SKIP_HI)));
  endfunction

  // Initial load and single-operation sequencer
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q         <= CMC_IDLE;
      load_start_o <= 1'b0;
      load_fetch_o <= 1'b0;
    end
    else if (ce_i)
    begin
      load_start_o <= 1'b0;
      load_fetch_o <= 1'b0;
      unique case (st_q)
        CMC_IDLE:
        begin
          if (prs[`CMC_B_LOAD])
            st_q <= CMC_LD_HALT;      // RULE1
          else if (prs[`CMC_B_ONEOP])
            st_q <= CMC_ONEOP;
        end
        CMC_LD_HALT: st_q <= CMC_LD_RST;  // RULE1
        CMC_LD_RST:  st_q <= CMC_LD_CLK;  // RULE1
        CMC_LD_CLK:
        begin
          load_start_o <= 1'b1;       // RULE1
          st_q         <= CMC_LD_WAIT;
        end
        CMC_LD_WAIT:
        begin
          // Exchange does the load itself and reports back
          if (initial_start_i)
          begin
            load_fetch_o <= 1'b1;     // RULE5
            st_q         <= CMC_IDLE;
          end
        end
        CMC_ONEOP:   st_q <= CMC_IDLE;    // RULE16
        default:     st_q <= CMC_IDLE;
      endcase
    end
  end

  // Resets: master from button or load sequence, computer, error-only
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      indicator_clr_o <= 1'b0;
      control_clr_o   <= 1'b0;
      error_clr_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      indicator_clr_o <= prs[`CMC_B_MRESET] | prs[`CMC_B_CRESET] | (st_q == CMC_LD_RST);  // RULE19 RULE20
      control_clr_o   <= prs[`CMC_B_MRESET] | prs[`CMC_B_CRESET] | (st_q == CMC_LD_RST);  // RULE19 RULE20
      error_clr_o     <= prs[`CMC_B_MRESET] | prs[`CMC_B_ERRCLR] | (st_q == CMC_LD_RST);  // RULE19 RULE20
    end
  end

  // Program halt, halt required and recovery triggers
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      program_halt_o   <= 1'b1;
      halt_required_o  <= 1'b1;
      recovery_req_o   <= 1'b1;
      recovery_go_o    <= 1'b0;
      lookahead_load_o <= 1'b0;
      fetch_next_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      recovery_go_o    <= 1'b0;
      lookahead_load_o <= 1'b0;
      fetch_next_o     <= 1'b0;
      if (prs[`CMC_B_MRESET] | prs[`CMC_B_CRESET] | (st_q == CMC_LD_RST))
      begin
        program_halt_o  <= 1'b1;      // RULE19 RULE20
        halt_required_o <= 1'b1;
        recovery_req_o  <= 1'b1;
      end
      else if (prs[`CMC_B_PHALT] | (st_q == CMC_LD_HALT))
      begin
        program_halt_o  <= 1'b1;      // RULE22 RULE1
        halt_required_o <= 1'b1;
      end
      else if (prs[`CMC_B_PSTART])
      begin
        // Invalid I unit contents are rebuilt before loading resumes
        recovery_go_o   <= recovery_req_o | ~iunit_valid_i;  // RULE22
        recovery_req_o  <= 1'b0;
        program_halt_o  <= 1'b0;      // RULE22
        halt_required_o <= 1'b0;
      end
      else if (st_q == CMC_ONEOP)
      begin
        // Behaves as a start immediately followed by a halt
        recovery_go_o    <= recovery_req_o | ~iunit_valid_i;  // RULE16
        recovery_req_o   <= 1'b0;
        lookahead_load_o <= 1'b1;     // RULE16
        fetch_next_o     <= buf_empty_i;  // RULE16
        program_halt_o   <= 1'b1;
      end
      else if (load_fetch_o)
        program_halt_o <= 1'b0;       // RULE5
      else if (prs[`CMC_B_SHOW] | prs[`CMC_B_CSHOW] | prs[`CMC_B_WRITE] | prs[`CMC_B_CWRITE])
        recovery_req_o <= 1'b1;       // Manual operations spoil the I unit
    end
  end

  // Display, store and instruction entry datapath
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mem_rd_o               <= 1'b0;
      mem_wr_o               <= 1'b0;
      mem_addr_o             <= '0;
      transfer_reg_o         <= '0;
      instruction_buffer_one <= '0;
      instruction_buffer_two <= '0;
      panel_addr_o           <= '0;
      shown_q                <= 1'b0;
      entered_inst_o         <= 1'b0;
    end
    else if (ce_i)
    begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      if (prs[`CMC_B_SHOW])
      begin
        instruction_buffer_two <= transfer_reg_o; // RULE7
        panel_addr_o           <= operator_address_switches; // RULE7
        mem_addr_o             <= operator_address_switches;
        mem_rd_o               <= show_ok(operator_address_switches); // RULE7
        shown_q                <= show_ok(operator_address_switches);
      end
      else if (prs[`CMC_B_CSHOW])
      begin
        instruction_buffer_two <= transfer_reg_o; // RULE8
        panel_addr_o           <= next_addr; // RULE8
        mem_addr_o             <= next_addr;
        mem_rd_o               <= 1'b1; // RULE8
        shown_q                <= 1'b1;
      end
      else if (prs[`CMC_B_WRITE])
      begin
        transfer_reg_o         <= mod_data; // RULE9
        instruction_buffer_one <= mod_data;
        panel_addr_o           <= operator_address_switches; // RULE9
        mem_addr_o             <= operator_address_switches;
        mem_wr_o               <= (operator_address_switches != AW'(`CMC_PROT_ADDR)); // RULE9
      end
      else if (prs[`CMC_B_CWRITE])
      begin
        transfer_reg_o         <= mod_data; // RULE10
        instruction_buffer_one <= mod_data;
        panel_addr_o           <= next_addr; // RULE10
        mem_addr_o             <= next_addr;
        mem_wr_o               <= (next_addr != AW'(`CMC_PROT_ADDR)); // RULE10
      end
      else if (prs[`CMC_B_ENTRY])
      begin
        instruction_buffer_one <= mod_data; // RULE11
        entered_inst_o         <= 1'b1; // RULE11
      end
      else if (mem_rvalid_i && shown_q)
      begin
        transfer_reg_o         <= mem_rdata_i; // RULE7 RULE8
        instruction_buffer_one <= mem_rdata_i;
        shown_q                <= 1'b0;
      end
      else if (prs[`CMC_B_PSTART] | prs[`CMC_B_ONEOP])
        entered_inst_o <= 1'b0;       // Entered word is executed first
    end
  end

  // Index storage test runs until error stop or switch normal
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      xs_run_q   <= 1'b0;
      xs_cycle_o <= 1'b0;
      xs_rcw_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!(xs_read_sw_i | xs_write_sw_i) || (xs_error_i && xs_err_stop_sw_i))
        xs_run_q <= 1'b0;             // RULE6
      else if (prs[`CMC_B_XSTEST] && maint)
        xs_run_q <= 1'b1;             // RULE6
      xs_cycle_o <= xs_run_q & (xs_read_sw_i | xs_write_sw_i);  // RULE6
      xs_rcw_o   <= xs_write_sw_i;
    end
  end

  // Scan ring control and error injection bit
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ring_reset_o <= 1'b0;
      ring_step_o  <= 1'b0;
      scan_start_o <= 1'b0;
      inject_bit_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ring_reset_o <= prs[`CMC_B_RRESET] & scan_test_switch_i & maint;  // RULE12
      ring_step_o  <= prs[`CMC_B_RSTEP] & scan_test_switch_i & maint;   // RULE12
      scan_start_o <= prs[`CMC_B_SCAN] & clk_stopped & maint & ~scan_inhibit_i;  // RULE13
      if (maint && fault_injection_permit)
      begin
        if (prs[`CMC_B_INJON])
          inject_bit_o <= 1'b1;       // RULE14
        else if (prs[`CMC_B_INJOFF])
          inject_bit_o <= 1'b0;       // RULE15
      end
    end
  end

  // Controlled clock: stop, start, slow rate and manual pulses
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clock_running_o <= 1'b1;
      stop_req_q      <= 1'b0;
      btn_stop_q      <= 1'b0;
      pulses_q        <= 2'h0;
      slow_q          <= 2'h0;
      ctl_pulse_o     <= 1'b0;
      ctl_phase_b_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      ctl_pulse_o <= 1'b0;
      if (st_q == CMC_LD_CLK)
      begin
        clock_running_o <= 1'b1;      // RULE1
        stop_req_q      <= 1'b0;
        btn_stop_q      <= 1'b0;
      end
      else if (prs[`CMC_B_CSTART] && btn_stop_q)
      begin
        clock_running_o <= 1'b1;      // RULE21
        btn_stop_q      <= 1'b0;
      end
      else if (prs[`CMC_B_CSTOP] && clock_running_o)
        stop_req_q <= 1'b1;           // RULE21
      else if (stop_req_q && clock_stop_phase_pulse)
      begin
        clock_running_o <= 1'b0;      // RULE21
        stop_req_q      <= 1'b0;
        btn_stop_q      <= 1'b1;
      end
      // Manual pulses alternate phase from the current one
      if (clk_stopped && pulses_q == 2'h0)
      begin
        if (prs[`CMC_B_PULSE1])
          pulses_q <= 2'h1;           // RULE18
        else if (prs[`CMC_B_PULSE2])
          pulses_q <= 2'h2;           // RULE18
        else if (prs[`CMC_B_PULSE3])
          pulses_q <= 2'h3;           // RULE18
        ctl_phase_b_o <= phase_b_i;
      end
      else if (clk_stopped)
      begin
        pulses_q    <= pulses_q - 2'h1;  // RULE18
        ctl_pulse_o <= 1'b1;
        if (ctl_pulse_o)
          ctl_phase_b_o <= ~ctl_phase_b_o;  // RULE18
      end
      else
      begin
        // One pulse in three while the slow button is held
        pulses_q <= 2'h0;
        slow_q   <= (slow_q == `CMC_SLOW_DIV - 2'h1) ? 2'h0 : slow_q + 2'h1;
        ctl_pulse_o <= ~lvl[`CMC_B_SLOW] | (slow_q == 2'h0);  // RULE17
        ctl_phase_b_o <= phase_b_i;
      end
    end
  end
endmodule

//--- inc/cmc_defines.svh
// Purpose: Console maintenance control constants
// Assumes: 64-bit words, 18-bit addresses
// Notes:   Offsets, positions and counts as macros
// Functional notes
// RULE1: Load: halt, reset, clock start, pulse
// RULE2: Exchange stops I/O, clears control words
// RULE3: Exchange writes synthetic word, starts read
// RULE4: First word at 4, refill from 4
// RULE5: Initial-start fetches via location 4
// RULE6: Index test runs until error or normal
// RULE7: Display loads addressed word, skips excluded
// RULE8: Consecutive display increments, then loads
// RULE9: Store switches, never to location 1
// RULE10: Consecutive store increments, never location 1
// RULE11: Entry loads buffer one for execution
// RULE12: Ring buttons need scan test, maintenance
// RULE13: Scan needs stop, maintenance, no inhibit
// RULE14: Inject-on sets bit 58 when permitted
// RULE15: Inject-off clears bit 58 when permitted
// RULE16: One instruction: start, then halt
// RULE17: Slow clock pulses at one third
// RULE18: Stopped clock: 1-3 alternating pulses
// RULE19: Master reset clears all, sets halts
// RULE20: Computer reset keeps errors; error reset
// RULE21: Stop after stop-phase; restart if button-stopped
// RULE22: Halt stops lookahead; start resumes, recovering
// RULE23: One press, one single-cycle request
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH
`define CMC_DATA_W 64
`define CMC_ADDR_W 18
`define CMC_LOAD_ADDR 18'h00004
`define CMC_PROT_ADDR 18'h00001
`define CMC_SKIP_ADDR_A 18'h00003
`define CMC_SKIP_LO 18'h00005
`define CMC_SKIP_HI 18'h0000c
`define CMC_INJ_BIT 58
`define CMC_SLOW_DIV 2'h3
`define CMC_NUM_BUTTONS 24
`define CMC_DATA_PAT_01 64'h5555555555555555
`define CMC_DATA_PAT_10 64'haaaaaaaaaaaaaaaa
// Button indices into the raw button bus
`define CMC_B_LOAD 0
`define CMC_B_XSTEST 1
`define CMC_B_SHOW 2
`define CMC_B_CSHOW 3
`define CMC_B_WRITE 4
`define CMC_B_CWRITE 5
`define CMC_B_ENTRY 6
`define CMC_B_RRESET 7
`define CMC_B_RSTEP 8
`define CMC_B_SCAN 9
`define CMC_B_INJON 10
`define CMC_B_INJOFF 11
`define CMC_B_ONEOP 12
`define CMC_B_PULSE1 13
`define CMC_B_PULSE2 14
`define CMC_B_PULSE3 15
`define CMC_B_MRESET 16
`define CMC_B_ERRCLR 17
`define CMC_B_CRESET 18
`define CMC_B_CSTART 19
`define CMC_B_CSTOP 20
`define CMC_B_PSTART 21
`define CMC_B_PHALT 22
`define CMC_B_SLOW 23
`endif

//--- inc/cmc_pkg.sv
// Purpose: Types for the console maintenance control block
// Assumes: Nothing beyond the defines header
// Notes:   Sequencer states and switch position encodings
package cmc_pkg;
  // Manual sequencer states
  typedef enum logic [2:0] {
    CMC_IDLE    = 3'b000,
    CMC_LD_HALT = 3'b001,
    CMC_LD_RST  = 3'b010,
    CMC_LD_CLK  = 3'b011,
    CMC_LD_WAIT = 3'b100,
    CMC_ONEOP   = 3'b101
  } cmc_state_type;
  // Three-position switch encoding
  typedef enum logic [1:0] {
    CMC_SW_NORMAL = 2'b00,
    CMC_SW_UP     = 2'b01,
    CMC_SW_DOWN   = 2'b10
  } cmc_sw_type;
endpackage

//--- hdl/cmc_press_sync.sv
// Purpose: Synchronise and edge-detect the operator pushbuttons
// Assumes: Buttons are asynchronous levels, active high while held
// Notes:   Three flops; a press counts once stages two and three agree
`timescale 1ns/1ps
module cmc_press_sync
#(
  parameter int N = 24                // Number of buttons
)
(
  input  wire logic         clock_i,  // System clock
  input  wire logic         rst_i,    // Asynchronous reset
  input  wire logic         ce_i,     // Clock enable
  input  wire logic [N-1:0] raw_i,    // Raw button levels
  output logic      [N-1:0] level_o,  // Filtered level
  output logic      [N-1:0] press_o   // One-cycle press pulse
);
  if (N < 1) $error("N must be positive");

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_btn
      logic s1_q;                     // Metastability stage, read by s2 only
      logic s2_q;                     // Second stage
      logic s3_q;                     // Third stage
      logic lvl_q;                    // Agreed level
      // Shift the button through three stages
      always_ff @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end
        else if (ce_i)
        begin
          s1_q <= raw_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // Level only moves when two and three agree; rising edge makes one pulse
      always_ff @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          lvl_q      <= 1'b0;
          press_o[g] <= 1'b0;
        end
        else if (ce_i)
        begin
          press_o[g] <= 1'b0;
          if (s2_q == s3_q)
          begin
            lvl_q      <= s3_q;
            press_o[g] <= s3_q & ~lvl_q;  // RULE23
          end
        end
      end
      assign level_o[g] = lvl_q;
    end
  endgenerate
endmodule

//--- testbench/cmc_console_ctrl_monitor.sv
// Purpose: Port assertions
// Assumes: Switches steady around presses
// Notes:   Bound from the bench top
`timescale 1ns/1ps
module cmc_console_ctrl_monitor
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        maintenance_state_switch,
  input wire logic        fault_injection_permit,
  input wire logic        scan_test_switch_i,
  input wire logic        ring_step_o,
  input wire logic        inject_bit_o,
  input wire logic        mem_wr_o,
  input wire logic [17:0] mem_addr_o,
  input wire logic        load_start_o,
  input wire logic        load_fetch_o,
  input wire logic        program_halt_o,
  input wire logic        clock_running_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Gated presses must leave their outputs quiet
  chk_ring_gate: assert property (ring_step_o |-> maintenance_state_switch && scan_test_switch_i)
    else $error("ring step while gated");
  chk_ring_single: assert property (ring_step_o |=> !ring_step_o)
    else $error("ring step longer than one cycle");
  chk_inject_gate: assert property ($changed(inject_bit_o) |-> maintenance_state_switch && fault_injection_permit)
    else $error("inject bit moved while gated");
  // Location one is never overwritten from the panel
  chk_write_guard: assert property (mem_wr_o |-> mem_addr_o != 18'h00001)
    else $error("write to protected location");
  // Load pulse only after halt and clock restart
  chk_load_order: assert property (load_start_o |-> program_halt_o && clock_running_o)
    else $error("load pulse out of order");
  chk_load_single: assert property (load_start_o |=> !load_start_o)
    else $error("load pulse longer than one cycle");
  chk_fetch_resume: assert property (load_fetch_o |=> !program_halt_o)
    else $error("halt kept after load fetch");
  chk_fetch_single: assert property (load_fetch_o |=> !load_fetch_o)
    else $error("load fetch longer than one cycle");
endmodule

//--- testbench/cmc_exchange_model.sv
// Purpose: Storage and exchange stand-in
// Assumes: Reads answer one cycle later
// Notes:   Idle read data toggles
`timescale 1ns/1ps
module cmc_exchange_model
(
  input  wire logic        clock_i,
  input  wire logic        mem_rd_o,
  input  wire logic        mem_wr_o,
  input  wire logic        load_start_o,
  input  wire logic [17:0] mem_addr_o,
  input  wire logic [63:0] transfer_reg_o,
  output logic             mem_rvalid_i = 1'h0,
  output logic      [63:0] mem_rdata_i = 64'h0,
  output logic             initial_start_i = 1'h0
);
  logic [63:0] mem [logic [17:0]]; // Sparse core image
  int          busy_q = 0;         // Cycles left in the load read
  // Storage answers; unwritten places return an address-derived word
  always @(posedge clock_i)
  begin
    mem_rvalid_i <= mem_rd_o;
    mem_rdata_i  <= mem_rd_o ? (mem.exists(mem_addr_o) ? mem[mem_addr_o] : {4{~mem_addr_o[15:0]}}) : ~mem_rdata_i;
    if (mem_wr_o) mem[mem_addr_o] = transfer_reg_o;
    if (load_start_o) busy_q <= 16;
    else if (busy_q > 0) busy_q <= busy_q - 1;
    if (busy_q == 2) mem[18'h00004] = 64'h0000100000000001;
    initial_start_i <= (busy_q == 1);
  end
endmodule

//--- testbench/cmc_console_ctrl_tb_top.sv
// Purpose: Self-checking bench
// Assumes: Switches change between presses
// Notes:   Fixed-seed random data and addresses
`timescale 1ns/1ps
`include "cmc_defines.svh"
module cmc_console_ctrl_tb_top;
  logic clock_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, maintenance_state_switch = 1'h1, fault_injection_permit = 1'h0;
  logic scan_test_switch_i = 1'h1, scan_inhibit_i = 1'h0, xs_read_sw_i = 1'h0, xs_write_sw_i = 1'h0;
  logic xs_err_stop_sw_i = 1'h0, xs_error_i = 1'h0, clock_stop_phase_pulse = 1'h0;
  logic phase_b_i = 1'h0, iunit_valid_i = 1'h0, buf_empty_i = 1'h0, initial_start_i, mem_rvalid_i, mem_rd_o, mem_wr_o;
  logic load_start_o, load_fetch_o, entered_inst_o, xs_cycle_o, xs_rcw_o, ring_reset_o, ring_step_o, scan_start_o;
  logic inject_bit_o, ctl_pulse_o, ctl_phase_b_o, clock_running_o, program_halt_o, halt_required_o, recovery_req_o;
  logic recovery_go_o, lookahead_load_o, fetch_next_o, indicator_clr_o, control_clr_o, error_clr_o;
  logic [23:0] buttons_i = 24'h0; // Raw pushbuttons
  logic [1:0]  data_pattern_sw01_i = 2'h0, data_pattern_sw10_i = 2'h0;
  logic [17:0] operator_address_switches = 18'h0, mem_addr_o, panel_addr_o, a;
  logic [63:0] operator_data_switches = 64'h0, mem_rdata_i, transfer_reg_o, d;
  logic [63:0] instruction_buffer_one, instruction_buffer_two;
  logic [3:0]  tp [5] = '{4'h0, 4'h8, 4'h2, 4'ha, 4'h5}; // Pattern pairs
  int          fails = 0, n_compared = 0, cyc = 0, n_pulse = 0, n_ring = 0, c;
  cmc_console_ctrl   uut (.*);
  cmc_exchange_model xm (.*);
  always #12.5 clock_i = ~clock_i;
  // Pulse tallies, hang guard
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    n_pulse <= n_pulse + ctl_pulse_o;
    n_ring <= n_ring + ring_step_o;
    if (cyc == 2000) conclude(1);
  end
  // Expected modified data
  function automatic logic [63:0] pat(logic [63:0] v, logic [3:0] m);
    return m == 4'h5 ? 64'h0 : m == 4'ha ? '1 : v | (m[3] ? `CMC_DATA_PAT_01 : 64'h0) | (m[1] ? `CMC_DATA_PAT_10 : 64'h0);
  endfunction
  task automatic chk(string n, logic [95:0] s, logic [95:0] e);
    n_compared++;
    if (s !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    fails += (s !== e);
  endtask
  // Long hold still gives one press
  task automatic press(int b);
    buttons_i[b] <= 1'h1;
    repeat (8) @(posedge clock_i);
    buttons_i[b] <= 1'h0;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic conclude(int extra);
    fails += extra;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    void'($urandom(70471));
    repeat (10) @(posedge clock_i);
    rst_i <= 1'h0;
    {phase_b_i, iunit_valid_i, buf_empty_i} <= 3'($urandom);
    for (int i = 0; i < 5; i++)
    begin
      a = 18'h00010 + 18'($urandom_range(0, 999));
      d = {$urandom, $urandom};
      {data_pattern_sw01_i, data_pattern_sw10_i, operator_address_switches, operator_data_switches} <= {tp[i], a, d};
      press(`CMC_B_WRITE);
      chk("store", {transfer_reg_o, panel_addr_o}, {pat(d, tp[i]), a});
      operator_data_switches <= ~d;
      press(`CMC_B_CWRITE);
      press(`CMC_B_SHOW);
      chk("show", {transfer_reg_o, instruction_buffer_two}, {pat(d, tp[i]), pat(~d, tp[i])});
      press(`CMC_B_CSHOW);
      chk("cons show", {instruction_buffer_one, panel_addr_o}, {pat(~d, tp[i]), a + 18'h1});
      operator_data_switches <= d;
      press(`CMC_B_ENTRY);
      chk("entry", {entered_inst_o, instruction_buffer_one}, {1'h1, pat(d, tp[i])});
    end
    operator_address_switches <= 18'h00001;
    press(`CMC_B_WRITE);
    operator_address_switches <= 18'h00003;
    press(`CMC_B_SHOW);
    chk("excluded show", transfer_reg_o, 64'h0);
    press(`CMC_B_INJON);
    fault_injection_permit <= 1'h1;
    press(`CMC_B_INJON);
    chk("inject on", inject_bit_o, 1'h1);
    press(`CMC_B_INJOFF);
    chk("inject off", inject_bit_o, 1'h0);
    c = n_ring;
    press(`CMC_B_RSTEP);
    scan_test_switch_i <= 1'h0;
    press(`CMC_B_RSTEP);
    chk("ring steps", n_ring - c, 1);
    press(`CMC_B_CSTOP);
    clock_stop_phase_pulse <= 1'h1;
    @(posedge clock_i) clock_stop_phase_pulse <= 1'h0;
    repeat (3) @(posedge clock_i);
    c = n_pulse;
    press(`CMC_B_PULSE3);
    chk("three pulses", {clock_running_o, 32'(n_pulse - c)}, 33'h3);
    press(`CMC_B_CSTART);
    press(`CMC_B_LOAD);
    for (int k = 0; k < 99 && load_fetch_o !== 1'h1; k++) @(negedge clock_i);
    @(negedge clock_i) chk("load resumes", {program_halt_o, clock_running_o}, 2'h1);
    @(posedge clock_i) press(`CMC_B_MRESET);
    chk("master reset", {program_halt_o, halt_required_o, recovery_req_o}, 3'h7);
    conclude(0);
  end
endmodule
bind cmc_console_ctrl cmc_console_ctrl_monitor mon (.*);
